// *** src/twm_regs.svh ***
/*
  Register offsets, field positions, status codes and timing figures of the
  two-wire master engine. Assumes it is included by its bare name.
*/
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH

// Byte offsets on the register bus.
`define TWM_CTRL_OFS 8'h00
`define TWM_STAT_OFS 8'h04
`define TWM_DATA_OFS 8'h08

// Control register bit positions.
`define TWM_C_DONE 7
`define TWM_C_ACK 6
`define TWM_C_START 5
`define TWM_C_STOP 4
`define TWM_C_WCOL 3
`define TWM_C_EN 2
`define TWM_C_IE 0

// Status register fields: code in the top five bits, prescaler at the bottom.
`define TWM_S_CODE_HI 7
`define TWM_S_CODE_LO 3
`define TWM_S_PRE_HI 1

// Status codes as read with the prescaler bits at zero.
`define TWM_ST_IDLE 8'hf8
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_TD_ACK 8'h28
`define TWM_ST_TD_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_RD_ACK 8'h50
`define TWM_ST_RD_NACK 8'h58

// Bit timing: a quarter of a 100 kHz bit, and the system clock period.
`define TWM_QTR_NS 2500
`define TWM_CLK_NS 20
`define TWM_LAST_BIT 4'h8

`endif

// *** src/twm_pkg.sv ***
/*
  Types shared by the two-wire master engine files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package twm_pkg;
  // Sequencer states of the bus engine.
  typedef enum logic [2:0] {
    TWM_IDLE, TWM_WAIT_FREE, TWM_START, TWM_TX, TWM_RX, TWM_STOP, TWM_HOLD
  } twm_state_e;
endpackage

// *** src/twm_sync.sv ***
/*
  Two-stage synchroniser for the sampled bus lines.
  Assumes the lines idle high, so both stages reset to one.
*/
`timescale 1ns/10ps
module twm_sync #(
  parameter int WIDTH = 2
) (
  clk,
  rst,
  din,
  dout
);
  input wire logic clk;
  input wire logic rst;
  input wire logic [WIDTH-1:0] din;
  output logic [WIDTH-1:0] dout;

  // First stage of each line; only the second stage reads it.
  logic [WIDTH-1:0] meta_r;

  // One pair of flip-flops per line.
  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r[i] <= 1'b1;
        dout[i] <= 1'b1;
      end else begin
        meta_r[i] <= din[i];
        dout[i] <= meta_r[i];
      end
    end
  end

  initial begin
    if (WIDTH < 1) $error("twm_sync needs at least one line");
  end
endmodule // twm_sync

// *** src/twm_engine.sv ***
/*
  Master side of a byte-oriented two-wire serial interface with an APB
  register port: control, status and data registers, a start/stop/byte
  sequencer and arbitration checking.
  Assumes external pull-ups on both lines and a 50 MHz system clock.
  // Operation
  // - Wait for free bus before START
  // - After START set flag, code 08
  // - Address direction bit selects transmit or receive
  // - Next action only after flag cleared
  // - Read address done: flag, code 38/40/48
  // - Codes assume prescaler bits read zero
  // - Received byte readable when flag set
  // - Stop request sends STOP, self-clears
  // - Stop plus start: STOP then START
  // - Start alone: repeated START, bus kept
  // - Repeated START reports 10, any address
  // - Write address after 10 switches to transmit
  // - Arbitration lost: release, or START later
  // - Code 38 for receive-side arbitration loss
  // - After 40/50 receive byte, ACK per enable
  // - Address NACK 48: no data, end only
  // - Received byte: 50 with ACK, 58 NACK
  // - After 58 only restart or stop
  // - Data write with flag low ignored, collision
  // - Flag set holds the transfer suspended
*/
`timescale 1ns/10ps
`include "twm_regs.svh"
module twm_engine
  import twm_pkg::*;
#(
  parameter int QTR_CYCLES = (`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
  clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  scl_i,
  scl_o,
  scl_oe,
  sda_i,
  sda_o,
  sda_oe,
  irq
);
  input wire logic clk;
  input wire logic rst;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [7:0] paddr;
  input wire logic [31:0] pwdata;
  output logic [31:0] prdata;
  output logic pready;
  output logic pslverr;
  input wire logic scl_i;
  output logic scl_o;
  output logic scl_oe;
  input wire logic sda_i;
  output logic sda_o;
  output logic sda_oe;
  output logic irq;

  // Software-visible state.
  logic flag_r; // Operation done flag.
  logic ack_en_r; // Return ACK on received bytes.
  logic start_r; // Start request.
  logic stop_r; // Stop request, cleared by hardware.
  logic wcol_r; // Write collision.
  logic en_r; // Interface enable.
  logic ie_r; // Interrupt enable.
  logic [1:0] pre_r; // Prescaler bits, stored only.
  logic [7:0] code_r; // Status code with prescaler bits at zero.
  logic [7:0] data_r; // Data register.

  // Sequencer state.
  twm_state_e state_r;
  logic [1:0] ph_r; // Quarter-bit phase.
  logic [3:0] bit_r; // Bit index, eight is the acknowledge slot.
  logic [7:0] shift_r; // Outgoing or incoming byte.
  logic [15:0] div_r; // Quarter-bit divider.
  logic scl_low_r; // Pull the clock line low.
  logic sda_low_r; // Pull the data line low.
  logic rx_mode_r; // Last address carried the read bit.
  logic is_addr_r; // Byte in flight is an address.
  logic rep_r; // This master owns the bus, so a START is a repeated one.
  logic arb_r; // Last event was arbitration loss.
  logic busy_r; // Bus seen between a START and a STOP.
  logic evt_r; // One-cycle pulse: raise the flag with evt_code_r.
  logic [7:0] evt_code_r;
  logic evt_rx_r; // With evt_r: shift_r holds a received byte.
  logic stop_done_r; // One-cycle pulse: STOP finished.

  // Synchronised lines and their previous values.
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;

  // Bus decode.
  logic wr_en;
  logic ctrl_wr;
  logic stat_wr;
  logic data_wr;
  logic mapped;
  logic clr_go;
  logic idle_go;
  logic tick;
  logic start_seen;
  logic stop_seen;

  twm_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({scl_i, sda_i}),
    .dout({scl_s, sda_s})
  );

  // Every register answers in its access phase without wait states.
  assign mapped = (paddr == `TWM_CTRL_OFS) || (paddr == `TWM_STAT_OFS) ||
                  (paddr == `TWM_DATA_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite;
  assign ctrl_wr = wr_en && (paddr == `TWM_CTRL_OFS);
  assign stat_wr = wr_en && (paddr == `TWM_STAT_OFS);
  assign data_wr = wr_en && (paddr == `TWM_DATA_OFS);
  // Writing a one to the flag while it is set releases the held transfer.
  assign clr_go = ctrl_wr && pwdata[`TWM_C_DONE] && pwdata[`TWM_C_EN] && flag_r;
  // A start request from an idle engine, with the flag clear.
  assign idle_go = ctrl_wr && pwdata[`TWM_C_START] && pwdata[`TWM_C_EN] &&
                   !flag_r && (state_r == TWM_IDLE);
  assign tick = (div_r == 16'(QTR_CYCLES - 1));
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // Lines are open drain: only a low is ever driven.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;
  assign irq = flag_r && ie_r;

  // Read data is captured in the setup phase so it stands in a flip-flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TWM_CTRL_OFS: prdata <= {24'h0, flag_r, ack_en_r, start_r, stop_r,
                                  wcol_r, en_r, 1'b0, ie_r};
        `TWM_STAT_OFS: prdata <= {24'h0, code_r[`TWM_S_CODE_HI:`TWM_S_CODE_LO],
                                  1'b0, pre_r};
        `TWM_DATA_OFS: prdata <= {24'h0, data_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Control bits; the flag set by hardware wins over a clear in one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
      ack_en_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ack_en_r <= pwdata[`TWM_C_ACK];
        start_r <= pwdata[`TWM_C_START];
        en_r <= pwdata[`TWM_C_EN];
        ie_r <= pwdata[`TWM_C_IE];
      end
      if (stop_done_r) begin
        stop_r <= 1'b0;
      end else if (ctrl_wr) begin
        stop_r <= pwdata[`TWM_C_STOP];
      end
      if (evt_r) begin
        flag_r <= 1'b1;
      end else if (ctrl_wr && pwdata[`TWM_C_DONE]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // Status code, prescaler bits, data register and collision bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_r <= `TWM_ST_IDLE;
      pre_r <= 2'h0;
      data_r <= 8'h0;
      wcol_r <= 1'b0;
    end else begin
      if (evt_r) begin
        code_r <= evt_code_r;
      end else if (clr_go || idle_go) begin
        code_r <= `TWM_ST_IDLE; // No valid code while the bus works.
      end
      if (stat_wr) begin
        pre_r <= pwdata[`TWM_S_PRE_HI:0];
      end
      if (evt_r && evt_rx_r) begin
        data_r <= shift_r;
      end else if (data_wr && flag_r) begin
        data_r <= pwdata[7:0];
      end
      if (data_wr && !flag_r) begin
        wcol_r <= 1'b1;
      end else if (data_wr) begin
        wcol_r <= 1'b0;
      end
    end
  end

  // Bus occupancy from START and STOP seen on the lines.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (start_seen) begin
        busy_r <= 1'b1;
      end else if (stop_seen || !en_r) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Quarter-bit divider, restarted whenever the engine is not stepping.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0;
    end else if (tick || state_r == TWM_IDLE || state_r == TWM_HOLD ||
                 state_r == TWM_WAIT_FREE) begin
      div_r <= 16'h0;
    end else begin
      div_r <= div_r + 16'h1;
    end
  end

  // Bus sequencer: each bit takes four quarter phases.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= TWM_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      rx_mode_r <= 1'b0;
      is_addr_r <= 1'b0;
      rep_r <= 1'b0;
      arb_r <= 1'b0;
      evt_r <= 1'b0;
      evt_code_r <= `TWM_ST_IDLE;
      evt_rx_r <= 1'b0;
      stop_done_r <= 1'b0;
    end else begin
      evt_r <= 1'b0;
      evt_rx_r <= 1'b0;
      stop_done_r <= 1'b0;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      if (!en_r && !idle_go) begin
        // Disabled: let go of both lines and forget the transfer.
        state_r <= TWM_IDLE;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
        rep_r <= 1'b0;
        arb_r <= 1'b0;
      end else begin
        case (state_r)
          TWM_IDLE: begin
            if (idle_go) begin
              state_r <= TWM_WAIT_FREE;
            end
          end
          TWM_WAIT_FREE: begin
            // Another master may own the bus; wait for its STOP.
            if (!busy_r) begin
              state_r <= TWM_START;
              rep_r <= 1'b0;
            end
          end
          TWM_HOLD: begin
            // Nothing moves on the bus until the flag is cleared.
            if (clr_go) begin
              if (arb_r) begin
                arb_r <= 1'b0;
                rep_r <= 1'b0;
                state_r <= pwdata[`TWM_C_START] ? TWM_WAIT_FREE : TWM_IDLE;
              end else if (pwdata[`TWM_C_STOP]) begin
                state_r <= TWM_STOP;
              end else if (pwdata[`TWM_C_START]) begin
                state_r <= TWM_START;
              end else if (rx_mode_r && (code_r == `TWM_ST_AR_ACK ||
                                         code_r == `TWM_ST_RD_ACK)) begin
                state_r <= TWM_RX;
              end else begin
                // Address after a START, or a data byte while transmitting.
                state_r <= TWM_TX;
                shift_r <= data_r;
                is_addr_r <= (code_r == `TWM_ST_START) || (code_r == `TWM_ST_RSTART);
                if (code_r == `TWM_ST_START || code_r == `TWM_ST_RSTART) begin
                  rx_mode_r <= data_r[0];
                end
              end
            end else begin
              state_r <= TWM_HOLD;
            end
          end
          default: begin
            // Stepping states keep their phase and bit until the next tick.
            ph_r <= ph_r;
            bit_r <= bit_r;
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              case (ph_r)
                2'h0: begin
                  // Clock is low, except for a START from idle: set up the data line.
                  case (state_r)
                    TWM_START: sda_low_r <= 1'b0;
                    TWM_STOP: sda_low_r <= 1'b1;
                    TWM_TX: sda_low_r <= (bit_r < `TWM_LAST_BIT) && !shift_r[7];
                    TWM_RX: sda_low_r <= (bit_r == `TWM_LAST_BIT) && ack_en_r;
                    default: sda_low_r <= 1'b0;
                  endcase
                end
                2'h1: begin
                  scl_low_r <= 1'b0;
                end
                2'h2: begin
                  // A slave stretching the clock holds this phase.
                  if (!scl_s) begin
                    ph_r <= ph_r;
                  end else if (state_r == TWM_START) begin
                    sda_low_r <= 1'b1;
                  end else if (state_r == TWM_STOP) begin
                    sda_low_r <= 1'b0;
                  end else if (!sda_low_r && !sda_s &&
                               (state_r == TWM_TX ? bit_r < `TWM_LAST_BIT
                                                  : bit_r == `TWM_LAST_BIT)) begin
                    // Someone else holds data low where we let it go high.
                    state_r <= TWM_HOLD;
                    scl_low_r <= 1'b0;
                    sda_low_r <= 1'b0;
                    arb_r <= 1'b1;
                    rep_r <= 1'b0;
                    evt_r <= 1'b1;
                    evt_code_r <= `TWM_ST_ARB;
                  end else if (state_r == TWM_RX && bit_r < `TWM_LAST_BIT) begin
                    shift_r <= {shift_r[6:0], sda_s};
                  end else if (bit_r == `TWM_LAST_BIT) begin
                    // Keep a one in the low bit of evt_code_r when the slave acknowledged (data low).
                    evt_rx_r <= 1'b0;
                    is_addr_r <= is_addr_r;
                    rep_r <= rep_r;
                    arb_r <= !sda_s ? 1'b0 : 1'b0;
                    evt_code_r <= {7'h0, !sda_s};
                  end
                end
                default: begin
                  ph_r <= 2'h0;
                  if (state_r == TWM_START) begin
                    scl_low_r <= 1'b1;
                    state_r <= TWM_HOLD;
                    evt_r <= 1'b1;
                    evt_code_r <= rep_r ? `TWM_ST_RSTART : `TWM_ST_START;
                    rep_r <= 1'b1;
                  end else if (state_r == TWM_STOP) begin
                    stop_done_r <= 1'b1;
                    rep_r <= 1'b0;
                    state_r <= start_r ? TWM_WAIT_FREE : TWM_IDLE;
                  end else if (bit_r != `TWM_LAST_BIT) begin
                    scl_low_r <= 1'b1;
                    bit_r <= bit_r + 4'h1;
                    if (state_r == TWM_TX) begin
                      shift_r <= {shift_r[6:0], 1'b0};
                    end
                  end else begin
                    // Byte and acknowledge done: report and wait.
                    scl_low_r <= 1'b1;
                    sda_low_r <= 1'b0;
                    state_r <= TWM_HOLD;
                    evt_r <= 1'b1;
                    evt_rx_r <= (state_r == TWM_RX);
                    if (state_r == TWM_RX) begin
                      evt_code_r <= ack_en_r ? `TWM_ST_RD_ACK : `TWM_ST_RD_NACK;
                    end else if (is_addr_r && rx_mode_r) begin
                      evt_code_r <= evt_code_r[0] ? `TWM_ST_AR_ACK
                                                  : `TWM_ST_AR_NACK;
                    end else if (is_addr_r) begin
                      evt_code_r <= evt_code_r[0] ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
                    end else begin
                      evt_code_r <= evt_code_r[0] ? `TWM_ST_TD_ACK
                                                  : `TWM_ST_TD_NACK;
                    end
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  initial begin
    if (QTR_CYCLES < 2 || QTR_CYCLES > 65535) $error("QTR_CYCLES out of range");
  end
endmodule // twm_engine

// *** testbench/twm_engine_asserts.sv ***
/*
  Port checker of the two-wire master engine, bound onto every instance.
  Assumes it sees the engine's ports only and one clock domain.
*/
`timescale 1ns/10ps
`include "twm_regs.svh"
module twm_engine_chk #(
  parameter int QTR_CYCLES = 125
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  // A control write is the only thing allowed to drop the flag.
  wire logic ctl_wr = psel && penable && pwrite && paddr == `TWM_CTRL_OFS;
  // True for the three decoded offsets.
  wire logic mapped = paddr == `TWM_CTRL_OFS || paddr == `TWM_STAT_OFS || paddr == `TWM_DATA_OFS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // SDA let go while SCL is released can only be a STOP.
  sequence stop_seen;
    $fell(sda_oe) && !scl_oe;
  endsequence
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in an access cycle");
  chk_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match the address decode");
  chk_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  chk_status_pad: assert property (psel && penable && !pwrite && paddr == `TWM_STAT_OFS |-> !prdata[2])
    else $error("status bit 2 not zero");
  chk_irq_clear_cause: assert property ($fell(irq) |-> $past(ctl_wr))
    else $error("flag dropped without a control write");
  chk_irq_keep: assert property (irq && !ctl_wr |=> irq)
    else $error("interrupt request dropped on its own");
  chk_hold_lines: assert property (irq && $past(irq) && !ctl_wr |=> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus lines moved while suspended");
  chk_start_scl_high: assert property ($rose(sda_oe) && !scl_oe |-> scl_i)
    else $error("start formed while clock line low");
  chk_stop_release: assert property (stop_seen |-> !scl_oe [*3])
    else $error("clock line pulled right after a stop");
  cov_flag: cover property ($rose(irq));
  cov_stop: cover property (stop_seen);
  cov_unmapped: cover property (psel && penable && pslverr);
endmodule // twm_engine_chk
bind twm_engine twm_engine_chk #(.QTR_CYCLES(QTR_CYCLES)) twm_engine_chk_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// *** testbench/twm_slave_model.sv ***
/*
  Behavioural slave on the two-wire bus: acknowledges its address, takes
  written bytes and sends a byte chain on reads.
  Assumes pull-ups, so a released line reads high on the wired nets.
*/
`timescale 1ns/10ps
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  output logic sda_low,
  output logic scl_low,
  output logic [7:0] rx_byte
);
  int bitn = 0; // Bits clocked since a START or the last acknowledge slot.
  logic [7:0] sh; // Incoming shift register, first bit ends at the top.
  logic [7:0] dat; // Byte sent in read mode.
  logic sel = 1'b0; // Addressed by the master.
  logic rd = 1'b0; // Read direction.
  logic addr_ph = 1'b0; // Address byte in progress.
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end
  // A START or repeated START restarts the address byte.
  always @(negedge sda) begin
    if (scl) begin
      bitn = 0;
      addr_ph = 1'b1;
      sel = 1'b0;
    end
  end
  // A STOP drops the selection.
  always @(posedge sda) begin
    if (scl) begin
      sel = 1'b0;
      addr_ph = 1'b0;
    end
  end
  // Bits are taken while SCL is high; a master NACK ends a read.
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
    end else if (sel && rd) begin
      if (sda) begin
        sel = 1'b0;
      end else begin
        dat = {dat[6:0], dat[7]} ^ 8'h35;
      end
    end
    bitn = bitn + 1;
  end
  // Outputs change only with SCL low; the stretch makes this side slow.
  always @(negedge scl) begin
    sda_low = 1'b0;
    if (bitn == 9) begin
      bitn = 0;
    end
    if (bitn == 8 && addr_ph) begin
      addr_ph = 1'b0;
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      sda_low = sel;
      dat = tx_byte;
    end else if (bitn == 8 && sel && !rd) begin
      rx_byte = sh;
      sda_low = (sh != 8'hff); // Byte ff is refused so the NACK path runs.
    end else if (bitn < 8 && sel && rd) begin
      sda_low = !dat[7 - bitn];
    end
    if (stretch) begin
      scl_low = 1'b1;
      #600;
      scl_low = 1'b0;
    end
  end
endmodule // twm_slave_model

// *** testbench/twm_engine_tb.sv ***
/*
  Self-checking bench of the two-wire master engine with a slave model.
  Assumes package, design, checker and slave model compile before it.
*/
`timescale 1ns/10ps
`include "twm_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module twm_engine_tb import twm_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic sl_sda_low, sl_scl_low, rx_last;
  logic stretch = 1'b0; // Slave holds SCL low after each fall when set.
  logic ext_sda_low = 1'b0; // Stands in for another master on the bus.
  logic [7:0] tx_byte = 8'h00, rx_byte, b;
  // Wired lines with pull-ups: low while any party pulls.
  wire logic scl_w = !(scl_oe || sl_scl_low);
  wire logic sda_w = !(sda_oe || sl_sda_low || ext_sda_low);
  int bad_count = 0, checked = 0;
  int seed = 32'h3631;
  logic [31:0] rdat;
  logic last_err;
  always #10 clk = !clk;
  twm_engine #(.QTR_CYCLES(2)) twm_engine_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  twm_slave_model twm_slave_model_i (.scl(scl_w), .sda(sda_w), .stretch(stretch),
    .tx_byte(tx_byte), .sda_low(sl_sda_low), .scl_low(sl_scl_low), .rx_byte(rx_byte));
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Waits for the flag, seen through the enabled interrupt request.
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Control word: flag cleared, enable and interrupt enable on.
  function automatic logic [31:0] ctl(input logic sta, input logic sto, input logic ack);
    return {24'h0, 1'b1, ack, sta, sto, 4'h5};
  endfunction
  // Next byte of the slave's read chain.
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7]} ^ 8'h35;
  endfunction
  // One action, then the masked status code once the flag rises.
  task automatic step(input logic [31:0] c, input logic [7:0] code);
    if (c != 32'h0) apb(1'b1, `TWM_CTRL_OFS, c);
    wait_irq();
    apb(1'b0, `TWM_STAT_OFS, 32'h0);
    `CHK("status", code, rdat[7:0] & 8'hf8)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped offset.
    apb(1'b0, `TWM_CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h0, rdat)
    apb(1'b0, `TWM_STAT_OFS, 32'h0);
    `CHK("status reset", 32'hf8, rdat)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 1'b1, last_err)
    // Data write with the flag low is dropped and flags a collision.
    apb(1'b1, `TWM_DATA_OFS, 32'h5a);
    apb(1'b0, `TWM_DATA_OFS, 32'h0);
    `CHK("data kept", 32'h0, rdat)
    apb(1'b0, `TWM_CTRL_OFS, 32'h0);
    `CHK("collision", 1'b1, rdat[`TWM_C_WCOL])
    apb(1'b1, `TWM_STAT_OFS, 32'h3);
    apb(1'b1, `TWM_CTRL_OFS, 32'h4);
    // Another master holds the bus; the START must wait for its STOP.
    ext_sda_low <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b1, `TWM_CTRL_OFS, ctl(1'b1, 1'b0, 1'b0));
    repeat (100) @(posedge clk);
    `CHK("busy wait", 2'b00, {scl_oe, sda_oe})
    ext_sda_low <= 1'b0;
    step(32'h0, `TWM_ST_START);
    `CHK("prescaler", 2'b11, rdat[1:0])
    repeat (50) @(posedge clk);
    `CHK("suspended", 1'b1, irq)
    apb(1'b1, `TWM_DATA_OFS, 32'h54);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_AW_ACK);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed)) & 8'hfe;
      stretch <= 1'($random(seed));
      apb(1'b1, `TWM_DATA_OFS, {24'h0, b});
      step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_TD_ACK);
      `CHK("slave byte", b, rx_byte)
    end
    apb(1'b0, `TWM_CTRL_OFS, 32'h0);
    `CHK("collision clear", 1'b0, rdat[`TWM_C_WCOL])
    apb(1'b1, `TWM_DATA_OFS, 32'hff);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_TD_NACK);
    step(ctl(1'b1, 1'b0, 1'b0), `TWM_ST_RSTART);
    // Read: ACK twice, NACK on the last byte.
    tx_byte <= 8'($random(seed));
    apb(1'b1, `TWM_DATA_OFS, 32'h55);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_AR_ACK);
    b = tx_byte;
    for (int i = 0; i < 3; i++) begin
      rx_last = (i == 2);
      stretch <= 1'($random(seed));
      step(ctl(1'b0, 1'b0, !rx_last), rx_last ? `TWM_ST_RD_NACK : `TWM_ST_RD_ACK);
      b = nxt(b);
      apb(1'b0, `TWM_DATA_OFS, 32'h0);
      `CHK("read byte", b, rdat[7:0])
    end
    step(ctl(1'b1, 1'b0, 1'b0), `TWM_ST_RSTART);
    apb(1'b1, `TWM_DATA_OFS, 32'h54);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_AW_ACK);
    step(ctl(1'b1, 1'b0, 1'b0), `TWM_ST_RSTART);
    apb(1'b1, `TWM_DATA_OFS, 32'h57);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_AR_NACK);
    step(ctl(1'b1, 1'b1, 1'b0), `TWM_ST_START);
    apb(1'b0, `TWM_CTRL_OFS, 32'h0);
    `CHK("stop cleared", 1'b0, rdat[`TWM_C_STOP])
    apb(1'b1, `TWM_DATA_OFS, 32'h54);
    step(ctl(1'b0, 1'b0, 1'b0), `TWM_ST_AW_ACK);
    // A plain STOP frees the bus and raises no flag.
    apb(1'b1, `TWM_CTRL_OFS, ctl(1'b0, 1'b1, 1'b0));
    repeat (300) @(posedge clk);
    `CHK("bus free", 3'b110, {scl_w, sda_w, irq})
    apb(1'b0, `TWM_CTRL_OFS, 32'h0);
    `CHK("stop self clear", 1'b0, rdat[`TWM_C_STOP])
    tally_and_finish();
  end
endmodule // twm_engine_tb
